// File: shared/flash_host_defs.svh
// Constants of the serial flash lock and security host controller
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH
// ----------------------------------------------------------------
// Register offsets (APB byte addresses)
// ----------------------------------------------------------------
`define FH_REG_CTRL 8'h00
`define FH_REG_ADDR 8'h04
`define FH_REG_DATA 8'h08
`define FH_REG_LEN 8'h0c
`define FH_REG_STAT 8'h10
`define FH_REG_RXD 8'h14
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define FH_CTRL_GO 31
`define FH_CTRL_A4 8
`define FH_STAT_ERR 1
`define FH_WIP_BIT 0
`define FH_LEN_RST 16'h0001
`define FH_SUS_MASK 8'h84
// ----------------------------------------------------------------
// Opcodes and data values
// ----------------------------------------------------------------
`define FH_OP_WRITE_ENABLE_CMD 8'h06
`define FH_OP_STAT_LO 8'h05
`define FH_OP_STAT_HI 8'h35
`define FH_OP_SEC_RD 8'h48
`define FH_OP_PARAM_RD 8'h5a
`define FH_OP_GLOCK 8'h7e
`define FH_OP_GUNLOCK 8'h98
`define FH_OP_NV_SET 8'he3
`define FH_OP_NV_CLR 8'he4
`define FH_OP_VL_WR 8'he1
`define FH_OP_NV_RD 8'he2
`define FH_OP_VL_RD 8'he0
`define FH_OP_RST_EN 8'h66
`define FH_OP_RST 8'h99
`define FH_LOCK_ON 8'hff
`define FH_LOCK_OFF 8'h00
`define FH_SEC_LO 4'h1
`define FH_SEC_HI 4'h3
// ----------------------------------------------------------------
// Timing and counts
// ----------------------------------------------------------------
`define FH_CLK_NS 4
`define FH_SCLK_NS 32
`define FH_SCLK_HALF ((`FH_SCLK_NS + 2 * `FH_CLK_NS - 1) / (2 * `FH_CLK_NS))
`define FH_CS_GAP_NS 20
`define FH_RST_WAIT_NS 100000
`define FH_EDGES_OPC 6'd8
`define FH_EDGES_ADR4 6'd40
`define FH_EDGES_ADR4_BYTE 6'd48
`endif

// File: shared/flash_host_pkg.sv
// Types of the serial flash host controller
package flash_host_pkg;
  // Command sequence step
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CHKWIP = 3'b001,
    S_CHKSUS = 3'b010,
    S_RSTEN = 3'b011,
    S_WRITE_ENABLE_CMD = 3'b100,
    S_MAIN = 3'b101
  } step_e;
  // Phase inside one chip-select frame
  typedef enum logic [2:0] {
    F_IDLE = 3'b000,
    F_OPC = 3'b001,
    F_ADR = 3'b010,
    F_DUM = 3'b011,
    F_WDT = 3'b100,
    F_RD = 3'b101,
    F_END = 3'b110
  } phase_e;
  // Byte shifter state
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_LOW = 2'b01,
    SH_HIGH = 2'b10
  } sh_e;
  // Whole state of the host
  typedef struct packed {
    step_e step;
    phase_e phase;
    logic inflight;
    logic [15:0] cnt;
    logic [7:0] fop;
    logic [7:0] prev_op;
    logic cs_n;
    logic [2:0] gap;
    logic [19:0] rec;
    logic go;
    logic [7:0] op;
    logic addr4;
    logic [31:0] addr;
    logic [7:0] wdata;
    logic [15:0] len;
    logic err;
    logic wip_seen;
    logic sus_seen;
    logic [7:0] rx_byte;
    logic rx_full;
    logic start;
    logic [7:0] tx;
    logic miso_m;
    logic miso_s;
    logic [31:0] prdata;
    logic [5:0] edges;
    logic sclk_prev;
  } host_s;
  // Whole state of the shifter
  typedef struct packed {
    sh_e ph;
    logic [7:0] div;
    logic [2:0] bitn;
    logic [7:0] sr;
    logic [7:0] rx;
    logic sclk;
    logic mosi;
    logic done;
  } shift_s;
endpackage

// File: shared/shift_if.sv
// Link between the command sequencer and the byte shifter
`timescale 1ns/1ps
interface shift_if;
  logic start; // Begin one byte
  logic [7:0] tx; // Byte to send
  logic miso; // Synchronised serial input
  logic done; // Byte finished
  logic [7:0] rx; // Byte received
  logic sclk; // Serial clock out
  logic mosi; // Serial data out
  modport ctrl (output start, tx, miso, input done, rx, sclk, mosi);
  modport eng (input start, tx, miso, output done, rx, sclk, mosi);
endinterface

// File: hw/spi_shifter.sv
// Byte shifter: divides the clock into the serial clock, mode 0
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module spi_shifter #(
  parameter int unsigned HALF = `FH_SCLK_HALF
) (
  input wire logic clk,
  input wire logic resetn,
  shift_if.eng bus
);
  import flash_host_pkg::*;
  localparam logic [7:0] HALF_M1 = 8'(HALF - 1);
  localparam int BYTE_CYC = 16 * int'(HALF) + 1;
  shift_s s_q; // Registered state
  shift_s s_d; // Next state
  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.ph)
      SH_IDLE: begin
        // Load byte, first bit out while clock low
        if (bus.start) begin
          s_d.sr = bus.tx;
          s_d.mosi = bus.tx[7];
          s_d.bitn = 3'd7;
          s_d.div = HALF_M1;
          s_d.ph = SH_LOW;
        end
      end
      SH_LOW: begin
        // Rising edge: take input bit
        if (s_q.div == 8'h00) begin
          s_d.sclk = 1'b1;
          s_d.rx = {s_q.rx[6:0], bus.miso};
          s_d.div = HALF_M1;
          s_d.ph = SH_HIGH;
        end else begin
          s_d.div = s_q.div - 8'h01;
        end
      end
      SH_HIGH: begin
        // Falling edge: next output bit
        if (s_q.div == 8'h00) begin
          s_d.sclk = 1'b0;
          if (s_q.bitn == 3'd0) begin
            s_d.done = 1'b1;
            s_d.ph = SH_IDLE;
          end else begin
            s_d.bitn = s_q.bitn - 3'd1;
            s_d.sr = {s_q.sr[6:0], 1'b0};
            s_d.mosi = s_q.sr[6];
            s_d.div = HALF_M1;
            s_d.ph = SH_LOW;
          end
        end else begin
          s_d.div = s_q.div - 8'h01;
        end
      end
      default: s_d.ph = SH_IDLE;
    endcase
  end
  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign bus.done = s_q.done;
  assign bus.rx = s_q.rx;
  assign bus.sclk = s_q.sclk;
  assign bus.mosi = s_q.mosi;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_byte_time: assert property (
    bus.start && s_q.ph == SH_IDLE |-> ##BYTE_CYC bus.done)
    else $error("byte did not finish in time");
  a_mosi_hold: assert property (
    $changed(bus.mosi) |-> $fell(bus.sclk) || $past(bus.start))
    else $error("serial data moved away from falling clock");
endmodule

// File: hw/flash_host.sv
// Host controller for serial flash lock, security and reset commands
//
// Behaviour
// - Security read: opcode, address, one dummy byte
// - Register number in bits 15:12, upper zero
// - Global lock/unlock frames carry opcode only
// - Set-lock needs latch, 32-bit address always
// - Deselect right after last set-lock address bit
// - Clear-all: latch set, deselect after eighth clock
// - Volatile write: latch, address, data 00/FF
// - Lock reads: opcode, 4-byte address, byte out
// - Reset enable frame, then reset frame
// - Check busy and suspend before reset
// - Write enable precedes latch-needing commands
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_host #(
  parameter int unsigned RST_WAIT =
    (`FH_RST_WAIT_NS + `FH_CLK_NS - 1) / `FH_CLK_NS,
  parameter logic [7:0] SUS_MASK = `FH_SUS_MASK
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flash_cs_n,
  output logic flash_sclk,
  output logic flash_mosi,
  input wire logic flash_miso
);
  import flash_host_pkg::*;
  localparam logic [2:0] GAP =
    3'((`FH_CS_GAP_NS + `FH_CLK_NS - 1) / `FH_CLK_NS);
  localparam logic [19:0] REC = 20'(RST_WAIT);
  host_s st_q; // Registered state
  host_s st_d; // Next state
  logic mapped; // Address hits a register
  logic busy; // Sequence or recovery running
  logic acc; // APB access phase
  logic launch; // Open a new frame
  step_e nstep; // Step of the new frame
  phase_e np; // Phase after the current one
  logic [1:0] idx; // Address byte index
  shift_if sh();
  // Byte engine
  spi_shifter u_shift (
    .clk(clk),
    .resetn(resetn),
    .bus(sh)
  );
  // ----------------------------------------------------------------
  // Frame layout helpers
  // ----------------------------------------------------------------
  // Address bytes that follow an opcode
  function automatic logic [15:0] nadr(logic [7:0] f, logic a4);
    unique case (f)
      `FH_OP_SEC_RD: nadr = a4 ? 16'd4 : 16'd3;
      `FH_OP_PARAM_RD: nadr = 16'd3;
      `FH_OP_NV_SET, `FH_OP_VL_WR, `FH_OP_NV_RD,
      `FH_OP_VL_RD: nadr = 16'd4;
      default: nadr = 16'd0;
    endcase
  endfunction
  // Byte count of one phase of a frame
  function automatic logic [15:0] cnt_of(phase_e ph, logic [7:0] f,
                                         host_s s);
    logic rd1;
    logic rdn;
    rd1 = f == `FH_OP_STAT_LO || f == `FH_OP_STAT_HI ||
          f == `FH_OP_NV_RD || f == `FH_OP_VL_RD;
    rdn = f == `FH_OP_SEC_RD || f == `FH_OP_PARAM_RD;
    unique case (ph)
      F_ADR: cnt_of = nadr(f, s.addr4);
      F_DUM: cnt_of = {15'd0, rdn};
      F_WDT: cnt_of = {15'd0, f == `FH_OP_VL_WR};
      F_RD: cnt_of = rd1 ? 16'd1 : (rdn ? s.len : 16'd0);
      default: cnt_of = 16'd0;
    endcase
  endfunction
  // First non-empty phase after ph
  function automatic phase_e nxt(phase_e ph, logic [7:0] f, host_s s);
    phase_e r;
    r = F_END;
    for (int k = 5; k >= 2; k--) begin
      if (k > int'(ph) && cnt_of(phase_e'(k[2:0]), f, s) != 16'd0) begin
        r = phase_e'(k[2:0]);
      end
    end
    return r;
  endfunction
  // Opcode sent in each step
  function automatic logic [7:0] step_op(step_e s, logic [7:0] op);
    unique case (s)
      S_CHKWIP: step_op = `FH_OP_STAT_LO;
      S_CHKSUS: step_op = `FH_OP_STAT_HI;
      S_RSTEN: step_op = `FH_OP_RST_EN;
      S_WRITE_ENABLE_CMD: step_op = `FH_OP_WRITE_ENABLE_CMD;
      default: step_op = op;
    endcase
  endfunction
  // Command accepted by the host
  function automatic logic valid_cmd(host_s s);
    unique case (s.op)
      `FH_OP_SEC_RD: valid_cmd = s.addr[31:16] == 16'h0000 &&
        s.addr[15:12] >= `FH_SEC_LO && s.addr[15:12] <= `FH_SEC_HI;
      `FH_OP_VL_WR: valid_cmd = s.wdata == `FH_LOCK_OFF ||
        s.wdata == `FH_LOCK_ON;
      `FH_OP_WRITE_ENABLE_CMD, `FH_OP_PARAM_RD, `FH_OP_GLOCK, `FH_OP_GUNLOCK,
      `FH_OP_NV_SET, `FH_OP_NV_CLR, `FH_OP_NV_RD, `FH_OP_VL_RD,
      `FH_OP_RST: valid_cmd = 1'b1;
      default: valid_cmd = 1'b0;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  always_comb begin
    mapped = paddr == `FH_REG_CTRL || paddr == `FH_REG_ADDR ||
             paddr == `FH_REG_DATA || paddr == `FH_REG_LEN ||
             paddr == `FH_REG_STAT || paddr == `FH_REG_RXD;
    acc = psel && penable;
    busy = st_q.step != S_IDLE || st_q.rec != 20'd0 || st_q.go;
  end
  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    launch = 1'b0;
    nstep = S_IDLE;
    np = F_END;
    idx = st_q.cnt[1:0] - 2'd1;
    st_d.start = 1'b0;
    // Input pin synchroniser
    st_d.miso_m = flash_miso;
    st_d.miso_s = st_q.miso_m;
    // Rising serial clocks in the frame
    st_d.sclk_prev = sh.sclk;
    if (sh.sclk && !st_q.sclk_prev && st_q.edges != 6'h3f) begin
      st_d.edges = st_q.edges + 6'd1;
    end
    // Read data captured in the setup cycle
    if (psel && !penable) begin
      unique case (paddr)
        `FH_REG_CTRL: st_d.prdata = {23'd0, st_q.addr4, st_q.op};
        `FH_REG_ADDR: st_d.prdata = st_q.addr;
        `FH_REG_DATA: st_d.prdata = {24'd0, st_q.wdata};
        `FH_REG_LEN: st_d.prdata = {16'd0, st_q.len};
        `FH_REG_STAT: st_d.prdata = {27'd0, st_q.rx_full,
          st_q.sus_seen, st_q.wip_seen, st_q.err, busy};
        `FH_REG_RXD: st_d.prdata = {24'd0, st_q.rx_byte};
        default: st_d.prdata = 32'h0000_0000;
      endcase
    end
    // Writes, ignored while a command runs
    if (acc && pwrite && !busy) begin
      unique case (paddr)
        `FH_REG_CTRL: begin
          st_d.op = pwdata[7:0];
          st_d.addr4 = pwdata[`FH_CTRL_A4];
          st_d.go = pwdata[`FH_CTRL_GO];
        end
        `FH_REG_ADDR: st_d.addr = pwdata;
        `FH_REG_DATA: st_d.wdata = pwdata[7:0];
        `FH_REG_LEN: st_d.len = pwdata[15:0];
        default: ;
      endcase
    end
    // Error clear and read-data pop
    if (acc && pwrite && paddr == `FH_REG_STAT && pwdata[`FH_STAT_ERR]) begin
      st_d.err = 1'b0;
    end
    if (acc && !pwrite && paddr == `FH_REG_RXD) begin
      st_d.rx_full = 1'b0;
    end
    // Reset recovery countdown
    if (st_q.rec != 20'd0) begin
      st_d.rec = st_q.rec - 20'd1;
    end
    // Frame engine
    unique case (st_q.phase)
      F_IDLE: begin
        // New command after recovery only
        if (st_q.go && st_q.rec == 20'd0) begin
          st_d.go = 1'b0;
          st_d.wip_seen = 1'b0;
          st_d.sus_seen = 1'b0;
          if (!valid_cmd(st_q)) begin
            st_d.err = 1'b1;
          end else if (st_q.op == `FH_OP_RST) begin
            nstep = S_CHKWIP;
            launch = 1'b1;
          end else if (st_q.op == `FH_OP_NV_SET ||
                       st_q.op == `FH_OP_NV_CLR ||
                       st_q.op == `FH_OP_VL_WR) begin
            nstep = S_WRITE_ENABLE_CMD;
            launch = 1'b1;
          end else begin
            nstep = S_MAIN;
            launch = 1'b1;
          end
        end
      end
      F_END: begin
        // Chip select high for the gap, then next step
        if (st_q.gap != 3'd0) begin
          st_d.gap = st_q.gap - 3'd1;
        end else begin
          st_d.prev_op = st_q.fop;
          st_d.phase = F_IDLE;
          st_d.step = S_IDLE;
          unique case (st_q.step)
            S_CHKWIP: begin
              nstep = S_CHKSUS;
              launch = 1'b1;
            end
            S_CHKSUS: begin
              // Refuse reset over busy or suspended work
              if (st_q.wip_seen || st_q.sus_seen) begin
                st_d.err = 1'b1;
              end else begin
                nstep = S_RSTEN;
                launch = 1'b1;
              end
            end
            S_RSTEN, S_WRITE_ENABLE_CMD: begin
              nstep = S_MAIN;
              launch = 1'b1;
            end
            default: begin
              if (st_q.fop == `FH_OP_RST) begin
                st_d.rec = REC;
              end
            end
          endcase
        end
      end
      default: begin
        if (st_q.inflight) begin
          // Byte finished
          if (sh.done) begin
            st_d.inflight = 1'b0;
            if (st_q.phase == F_RD) begin
              if (st_q.step == S_CHKWIP) begin
                st_d.wip_seen = sh.rx[`FH_WIP_BIT];
              end else if (st_q.step == S_CHKSUS) begin
                st_d.sus_seen = |(sh.rx & SUS_MASK);
              end else begin
                st_d.rx_byte = sh.rx;
                st_d.rx_full = 1'b1;
              end
            end
            if (st_q.cnt == 16'd1) begin
              // Deselect right after the last byte
              np = nxt(st_q.phase, st_q.fop, st_q);
              st_d.phase = np;
              st_d.cnt = cnt_of(np, st_q.fop, st_q);
              if (np == F_END) begin
                st_d.cs_n = 1'b1;
                st_d.gap = GAP - 3'd1;
              end
            end else begin
              st_d.cnt = st_q.cnt - 16'd1;
            end
          end
        end else if (!(st_q.phase == F_RD && st_q.step == S_MAIN &&
                       st_q.rx_full)) begin
          // Issue next byte; reads wait for software
          st_d.start = 1'b1;
          st_d.inflight = 1'b1;
          unique case (st_q.phase)
            F_OPC: st_d.tx = st_q.fop;
            F_ADR: st_d.tx = st_q.addr[{idx, 3'b000} +: 8];
            F_WDT: st_d.tx = st_q.wdata;
            default: st_d.tx = 8'h00;
          endcase
        end
      end
    endcase
    // Open a frame
    if (launch) begin
      st_d.step = nstep;
      st_d.phase = F_OPC;
      st_d.cnt = 16'd1;
      st_d.cs_n = 1'b0;
      st_d.fop = step_op(nstep, st_q.op);
      st_d.edges = 6'd0;
    end
  end
  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.cs_n <= 1'b1;
      st_q.len <= `FH_LEN_RST;
    end else begin
      st_q <= st_d;
    end
  end
  // Outputs
  assign sh.start = st_q.start;
  assign sh.tx = st_q.tx;
  assign sh.miso = st_q.miso_s;
  assign flash_cs_n = st_q.cs_n;
  assign flash_sclk = sh.sclk;
  assign flash_mosi = sh.mosi;
  assign prdata = st_q.prdata;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_global_len: assert property (
    $rose(flash_cs_n) && (st_q.fop == `FH_OP_GLOCK ||
    st_q.fop == `FH_OP_GUNLOCK) |-> st_q.edges == `FH_EDGES_OPC)
    else $error("global lock frame length wrong");
  a_set_len: assert property (
    $rose(flash_cs_n) && st_q.fop == `FH_OP_NV_SET
    |-> st_q.edges == `FH_EDGES_ADR4)
    else $error("set-lock frame length wrong");
  a_clear_len: assert property (
    $rose(flash_cs_n) && st_q.fop == `FH_OP_NV_CLR
    |-> st_q.edges == `FH_EDGES_OPC)
    else $error("clear-all frame length wrong");
  a_vol_write: assert property (
    $fell(flash_cs_n) && st_q.fop == `FH_OP_VL_WR
    |-> (st_q.wdata == `FH_LOCK_ON || st_q.wdata == `FH_LOCK_OFF)
    ##[1:1000] $rose(flash_cs_n) && st_q.edges == `FH_EDGES_ADR4_BYTE)
    else $error("volatile write frame wrong");
  a_lock_read: assert property (
    $rose(flash_cs_n) && (st_q.fop == `FH_OP_NV_RD ||
    st_q.fop == `FH_OP_VL_RD) |-> st_q.edges == `FH_EDGES_ADR4_BYTE)
    else $error("lock read frame length wrong");
  a_sec_addr: assert property (
    $fell(flash_cs_n) && st_q.fop == `FH_OP_SEC_RD
    |-> st_q.addr[31:16] == 16'h0000 && st_q.addr[15:12] != 4'h0 &&
    st_q.addr[15:12] <= `FH_SEC_HI)
    else $error("security read address out of range");
  a_write_enable_cmd_first: assert property (
    $fell(flash_cs_n) && (st_q.fop == `FH_OP_NV_SET ||
    st_q.fop == `FH_OP_NV_CLR || st_q.fop == `FH_OP_VL_WR)
    |-> st_q.prev_op == `FH_OP_WRITE_ENABLE_CMD)
    else $error("latch command without write enable");
  a_reset_pair: assert property (
    $fell(flash_cs_n) && st_q.fop == `FH_OP_RST
    |-> st_q.prev_op == `FH_OP_RST_EN)
    else $error("reset without enable frame");
  a_reset_check: assert property (
    $fell(flash_cs_n) && st_q.fop == `FH_OP_RST_EN
    |-> !st_q.wip_seen && !st_q.sus_seen && st_q.prev_op == `FH_OP_STAT_HI)
    else $error("reset issued without status check");
  a_recover: assert property (
    st_q.rec != 20'd0 |-> flash_cs_n)
    else $error("frame during reset recovery");
  a_cs_idle: assert property (
    st_q.phase == F_IDLE |-> flash_cs_n && !flash_sclk)
    else $error("select active while idle");
endmodule

// File: test/flash_dev_model.sv
// Behavioural serial flash device answering the host controller
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int BUSY_NS = 100,
  parameter int REC_NS = 60
) (
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic four,
  input wire logic sus_in,
  output logic miso
);
  logic [7:0] op, sr, o;
  logic [7:0] nl[16];
  logic [7:0] vl[16];
  logic [31:0] ad;
  logic [3:0] ps;
  logic write_enable_latch, write_in_progress, arm, rec, pk, nxt;
  int nb, hl, rst_cnt;
  // Address bytes per opcode
  function automatic int na(logic [7:0] c);
    case (c)
      8'h48: return four ? 4 : 3;
      8'h5a: return 3;
      8'h05, 8'h35: return 0;
      default: return 4;
    endcase
  endfunction
  // Byte k of a read answer
  function automatic logic [7:0] dbyte(int k);
    logic [31:0] a;
    a = {ad[31:12], ad[11:0] + 12'(k)};
    case (op)
      8'h48: return a[7:0] ^ {a[11:8], a[15:12]};
      8'h5a: return a[7:0] + 8'h50;
      8'he2: return nl[ad[19:16]];
      8'he0: return vl[ad[19:16]];
      8'h05: return {6'h0, write_enable_latch, write_in_progress};
      default: return sus_in ? 8'h84 : 8'h00;
    endcase
  endfunction
  initial begin
    {write_enable_latch, write_in_progress, arm, rec, miso, rst_cnt} = 0;
    for (int i = 0; i < 16; i++) begin
      nl[i] = 8'h00;
      vl[i] = 8'h00;
    end
  end
  always @(negedge cs_n) begin
    nb = 0;
    ad = 0;
    op = 0;
  end
  // Input bits sampled on the rising serial edge
  always @(posedge sclk) if (!cs_n && !rec) begin
    sr = {sr[6:0], mosi};
    nb++;
    if (nb == 8) op = sr;
    else if (nb <= 8 + 8 * na(op) && nb % 8 == 0) ad = {ad[23:0], sr};
    hl = 8 + 8 * na(op) + ((op == 8'h48 || op == 8'h5a) ? 8 : 0);
    if (op inside {8'h48, 8'h5a, 8'he2, 8'he0, 8'h05, 8'h35} &&
        nb >= hl && (nb - hl) % 8 == 0 && !(write_in_progress && op[7:4] == 4'he))
      o = dbyte((nb - hl) / 8);
  end
  // Output bits change on the falling serial edge
  always @(negedge sclk) if (!cs_n) begin
    miso <= o[7];
    o = {o[6:0], ~o[7]};
  end
  // Frame end: output inverted, commands take effect
  always @(posedge cs_n) begin
    miso <= ~miso;
    if (!rec && !write_in_progress) begin
      nxt = (op == 8'h66 && nb == 8);
      ps = ad[19:16];
      case (op)
        8'h06: if (nb == 8) write_enable_latch = 1;
        8'h7e: if (nb == 8) foreach (vl[i]) vl[i] = 8'hff;
        8'h98: if (nb == 8) foreach (vl[i]) vl[i] = 8'h00;
        8'he3: if (nb == 40 && write_enable_latch) {pk, write_in_progress} = 2'b11;
        8'he4: if (nb == 8 && write_enable_latch) {pk, write_in_progress} = 2'b01;
        8'he1: if (nb == 48 && write_enable_latch && (sr == 8'h00 || sr == 8'hff)) begin
          vl[ps] = sr;
          write_enable_latch = 0;
        end
        8'h99: if (nb == 8 && arm) begin
          {write_enable_latch, write_in_progress} = 0;
          rst_cnt++;
          rec = 1;
        end
        default: ;
      endcase
      arm = nxt;
    end
  end
  // Self-timed lock cycles
  always @(posedge write_in_progress) begin
    #BUSY_NS;
    if (pk) nl[ps] = 8'hff;
    else foreach (nl[i]) nl[i] = 8'h00;
    {write_enable_latch, write_in_progress} = 0;
  end
  always @(posedge rec) begin
    #REC_NS;
    rec = 0;
  end
endmodule

// File: test/flash_host_bench.sv
// Self-checking bench of the flash host controller
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_host_bench;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic four = 0, sus = 0, serr, pready, pslverr, cs_n, sclk, mosi, miso;
  logic [7:0] paddr = 0, q[$];
  logic [31:0] pwdata = 0, prdata, r, st, a, rn;
  int bad_count = 0, n_checks = 0, cyc = 0, seed = 32'h2b4c;
  always #2 clk = ~clk;
  flash_host #(.RST_WAIT(20)) i_flash_host(.clk(clk), .resetn(resetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_cs_n(cs_n), .flash_sclk(sclk), .flash_mosi(mosi),
    .flash_miso(miso));
  // Long busy cycle so a reset right after set-lock meets a busy device
  flash_dev_model #(.BUSY_NS(600)) i_flash_dev_model(.cs_n(cs_n),
    .sclk(sclk), .mosi(mosi), .four(four), .sus_in(sus), .miso(miso));
  task report_and_stop;
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      report_and_stop;
    end
  end
  task chk(string n, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // One APB transfer, held until pready
  task apb(bit w, logic [7:0] ad, logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Issue one command and gather its read bytes
  task cmd(logic [7:0] op, logic [31:0] ad, logic [7:0] d, logic [15:0] n);
    q = {};
    apb(1, `FH_REG_ADDR, ad);
    apb(1, `FH_REG_DATA, {24'h0, d});
    apb(1, `FH_REG_LEN, {16'h0, n});
    apb(1, `FH_REG_CTRL, {1'b1, 22'h0, four, op});
    do begin
      apb(0, `FH_REG_STAT, 0);
      st = r;
      if (st[4] === 1'b1) begin
        apb(0, `FH_REG_RXD, 0);
        q.push_back(r[7:0]);
      end
    end while (st[0] !== 1'b0 || st[4] === 1'b1);
  endtask
  task errchk(logic e);
    apb(0, `FH_REG_STAT, 0);
    chk("err", e, r[1]);
    if (r[1] === 1'b1) apb(1, `FH_REG_STAT, 32'h2);
  endtask
  task lk(logic [7:0] op, logic [7:0] e);
    cmd(op, a, 0, 1);
    chk("lock_byte", e, q[0]);
  endtask
  function automatic logic [7:0] sec_exp(logic [31:0] x, int k);
    x[11:0] = x[11:0] + 12'(k);
    return x[7:0] ^ {x[11:8], x[15:12]};
  endfunction
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1;
    apb(0, `FH_REG_LEN, 0);
    chk("len_rst", 32'h1, r);
    apb(1, 8'h18, 0);
    chk("slverr", 1, serr);
    // Security reads across the wrap, both address modes
    for (int m = 0; m < 2; m++) begin
      four <= m[0];
      rn = $random(seed);
      a = {16'h0, 4'(rn % 3 + 1), 12'hffe};
      cmd(8'h48, a, 0, 4);
      chk("sec_cnt", 4, q.size());
      foreach (q[i]) chk("sec_byte", sec_exp(a, i), q[i]);
    end
    cmd(8'h48, 32'h4000, 0, 1);
    errchk(1);
    cmd(8'h5a, 32'h10, 0, 2);
    chk("param", 16'h6061, {q[0], q[1]});
    rn = $random(seed);
    a = {12'h0, rn[3:0], 16'h0};
    cmd(8'h7e, 0, 0, 1);
    lk(8'he0, 8'hff);
    cmd(8'h98, 0, 0, 1);
    lk(8'he0, 8'h00);
    cmd(8'he3, a, 0, 1);
    // Reset attempt while the set-lock cycle still runs
    cmd(8'h99, 0, 0, 1);
    chk("wip_seen", 1, st[2]);
    errchk(1);
    chk("rst_cnt", 0, i_flash_dev_model.rst_cnt);
    lk(8'he2, 8'hff);
    a[16] = ~a[16];
    lk(8'he2, 8'h00);
    a[16] = ~a[16];
    cmd(8'he4, 0, 0, 1);
    lk(8'he2, 8'h00);
    cmd(8'he1, a, 8'hff, 1);
    lk(8'he0, 8'hff);
    cmd(8'he1, a, 8'h5a, 1);
    errchk(1);
    cmd(8'h03, 0, 0, 1);
    errchk(1);
    // Plain write enable is a legal command of its own
    cmd(8'h06, 0, 0, 1);
    errchk(0);
    sus <= 1;
    cmd(8'h99, 0, 0, 1);
    chk("sus_seen", 1, st[3]);
    errchk(1);
    chk("rst_cnt", 0, i_flash_dev_model.rst_cnt);
    sus <= 0;
    cmd(8'h99, 0, 0, 1);
    errchk(0);
    chk("rst_cnt", 1, i_flash_dev_model.rst_cnt);
    lk(8'he0, 8'hff);
    report_and_stop;
  end
endmodule
